//--- design/rtc_consts.svh
// register map, field positions, reset values and timing figures of the rtc block
// Summary of operation
// - bits fixed at zero read back zero whatever the host wrote into them
// - addresses 0Fh to 7Fh read zero and ignore writes
// - time, calendar and alarm values are stored, counted and exchanged in bcd
// - hours bit 6 high selects 12-hour counting, low selects 24-hour counting
// - in 12-hour mode hours bit 5 high means afternoon
// - in 24-hour mode hours bit 5 is the tens bit for hours 20 to 23
// - alarm registers 07h to 0Ah each carry a mask bit in bit 7
// - with no masks set, alarm on full match of 00h to 03h, weekly
// - masking day, hours, minutes, seconds widens match to daily, hourly, minutely, every second
// - oscillator stop low runs oscillator; high on backup halts it into standby
// - on main supply oscillator runs, clock advances only while oscillator stop is low
// - write lock high makes the device ignore register writes, except writes to the control register
// - channel select 00 off, 01 input 0, 10 input 1, 11 input 2
// - interrupt follows alarm flag only while alarm interrupt enable is high
// - conversion pending high warns that the converter result will change soon
// - battery low status reports the backup supply comparator
// - alarm flag sets when current time meets the masked alarm comparison
// - any host read or write of an alarm register clears the alarm flag
// - power-up sets oscillator stop and both watchdog delay bits, clears lock and channel
// - control and status bit layouts, unused bits read zero
// - interrupt is active high and holds while flag and enable both stay set
// - command byte holds address in bits 6:0 and write direction in bit 7
`ifndef RTC_CONSTS_SVH
`define RTC_CONSTS_SVH
`define RTC_A_SEC       7'h00
`define RTC_A_MIN       7'h01
`define RTC_A_HOUR      7'h02
`define RTC_A_DAY       7'h03
`define RTC_A_DATE      7'h04
`define RTC_A_MONTH     7'h05
`define RTC_A_YEAR      7'h06
`define RTC_A_ALM_FIRST 7'h07
`define RTC_A_ALM_LAST  7'h0A
`define RTC_A_CTRL      7'h0B
`define RTC_A_STAT      7'h0C
`define RTC_A_WDOG      7'h0D
`define RTC_A_ADC       7'h0E
`define RTC_NUM_TM      11
`define RTC_TM_WMASK    88'hFF_FFFF_FFFF_1F3F_077F_7F7F
`define RTC_TM_RESET    88'h00_0000_0000_0101_0100_0000
`define RTC_CTRL_WMASK  8'hF1
`define RTC_CTRL_RESET  8'h80
`define RTC_WDOG_WMASK  8'h03
`define RTC_WDOG_RESET  8'h03
`define RTC_CTL_OSC_STOP 7
`define RTC_CTL_LOCK    6
`define RTC_CTL_CHAN_HI 5
`define RTC_CTL_CHAN_LO 4
`define RTC_CTL_AIE     0
`define RTC_HR_MODE     6
`define RTC_HR_PM       5
`define RTC_ALM_MASK    7
`define RTC_CMD_DIR     7
`define RTC_XTAL_HZ     32768
`endif

//--- design/rtc_pkg.sv
// types shared by the rtc block
package rtc_pkg;
    // one host access handed from the serial side to the core
    typedef struct packed {
        logic       wr;
        logic [6:0] addr;
        logic [7:0] data;
    } rtc_req_t;
    // converter handshake on sys_clk
    typedef struct packed {
        logic       pending;
        logic       done;
        logic [7:0] data;
    } rtc_conv_t;
    typedef enum logic [1:0] {LNK_CMD, LNK_WR, LNK_RD} rtc_link_t;
endpackage : rtc_pkg

//--- design/rtc_core.sv
// rtc timekeeping, alarm, control and status with its three-wire register port
`timescale 1ns/1ps
`include "rtc_consts.svh"
module rtc_core
    import rtc_pkg::*;
#(
    parameter int XTAL_DIV = `RTC_XTAL_HZ
)(
    input  logic            sys_clk,
    input  logic            rst,
    input  logic            ce,
    input  logic            link_sclk,
    input  logic            link_cs,
    input  logic            link_io_in,
    output logic            link_io_out,
    output logic            link_io_oe_n,
    input  logic            xtal_in,
    input  logic            main_supply_ok,
    input  logic            battery_low_cmp,
    input  rtc_conv_t       conv,
    output logic            irq,
    output logic            osc_run,
    output logic            standby,
    output logic            adc_enable,
    output logic [2:0]      adc_input_sel,
    output logic [1:0]      watchdog_delay
);
    localparam int DW = $clog2(XTAL_DIV);
    localparam logic [87:0] TM_WMASK = `RTC_TM_WMASK;
    localparam logic [87:0] TM_RESET = `RTC_TM_RESET;

    // link side
    rtc_link_t      lphase;
    logic [2:0]     lcnt;
    logic [7:0]     lshift;
    logic [6:0]     laddr;
    logic [7:0]     lout;
    rtc_req_t       lreq;
    logic           ltog;
    logic [7:0]     lbyte;

    // core side
    logic [7:0]     tm [0:`RTC_NUM_TM-1];
    logic [7:0]     ctrl;
    logic [7:0]     wdog;
    logic [7:0]     adc_reg;
    logic [7:0]     rd_hold;
    logic [7:0]     rd_val;
    logic           alarm_flag;
    logic [2:0]     tsync;
    logic [2:0]     pin_meta;
    logic [2:0]     pin_sync;
    logic           xtal_last;
    logic [DW-1:0]  div;
    logic           tick;
    logic           tick_d;
    logic [3:0]     fld_hit;
    logic           req_ev;
    logic           host_wr;
    logic           alm_access;
    logic           main_s;
    logic           batt_s;
    logic           osc_stop;
    logic [7:0]     next_sec;
    logic [7:0]     next_min;
    logic [7:0]     next_hour;
    logic [7:0]     next_day;
    logic [7:0]     next_date;
    logic [7:0]     next_month;
    logic [7:0]     next_year;
    logic           c_min;
    logic           c_hour;
    logic           c_day;
    logic           c_month;
    logic           c_year;
    logic           leap;
    logic [7:0]     hr12_inc;
    logic [7:0]     hr24_inc;

    // bcd increment of one byte, no wrap
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
    endfunction : bcd_inc

    // last bcd date of a bcd month
    function automatic logic [7:0] month_days(input logic [7:0] m, input logic lp);
        case (m)
            8'h02:                      month_days = lp ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: month_days = 8'h30;
            default:                    month_days = 8'h31;
        endcase
    endfunction : month_days

    // burst address wraps after the converter result
    function automatic logic [6:0] addr_next(input logic [6:0] a);
        addr_next = (a == `RTC_A_ADC) ? `RTC_A_SEC : a + 7'h01;
    endfunction : addr_next

    assign lbyte = {link_io_in, lshift[7:1]}; // lsb first, byte complete on 8th rise

    // serial framing; chip select low aborts and restarts at the command byte
    always_ff @(posedge link_sclk or negedge link_cs)
    begin
        if (!link_cs)
        begin
            lphase <= LNK_CMD;
            lcnt   <= 3'h0;
            lshift <= 8'h00;
            laddr  <= 7'h00;
        end
        else
        begin
            lcnt   <= lcnt + 3'h1;
            lshift <= lbyte;
            case (lphase)
                LNK_CMD:
                    if (lcnt == 3'h7)
                    begin
                        laddr  <= lbyte[6:0];
                        lphase <= lbyte[`RTC_CMD_DIR] ? LNK_WR : LNK_RD;
                    end
                LNK_WR:
                    if (lcnt == 3'h7)
                        laddr <= addr_next(laddr);
                LNK_RD:
                    if (lcnt == 3'h0)
                        laddr <= addr_next(laddr);
                default:
                    lphase <= LNK_CMD;
            endcase
        end
    end

    // requests to the core; toggle survives chip select so no false event appears
    always_ff @(posedge link_sclk or posedge rst)
    begin
        if (rst)
        begin
            lreq <= '0;
            ltog <= 1'b0;
        end
        else if (lphase == LNK_CMD && lcnt == 3'h6)
        begin
            // address known one bit early: prefetch so the first read bit is ready
            lreq <= '{wr: 1'b0, addr: {link_io_in, lshift[7:2]}, data: 8'h00};
            ltog <= ~ltog;
        end
        else if (lphase == LNK_WR && lcnt == 3'h7)
        begin
            lreq <= '{wr: 1'b1, addr: laddr, data: lbyte};
            ltog <= ~ltog;
        end
        else if (lphase == LNK_RD && lcnt == 3'h0)
        begin
            lreq <= '{wr: 1'b0, addr: addr_next(laddr), data: 8'h00};
            ltog <= ~ltog;
        end
    end

    // read data leaves on falling edges; rd_hold settles many core cycles before use
    always_ff @(negedge link_sclk or negedge link_cs)
    begin
        if (!link_cs)
        begin
            link_io_out  <= 1'b0;
            link_io_oe_n <= 1'b1;
            lout         <= 8'h00;
        end
        else if (lphase == LNK_RD)
        begin
            link_io_oe_n <= 1'b0;
            if (lcnt == 3'h0)
            begin
                link_io_out <= rd_hold[0];
                lout        <= {1'b0, rd_hold[7:1]};
            end
            else
            begin
                link_io_out <= lout[0];
                lout        <= {1'b0, lout[7:1]};
            end
        end
    end

    // request toggle and pin synchronisers; first stages feed only second stages
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            tsync    <= 3'b000;
            pin_meta <= 3'b000;
            pin_sync <= 3'b000;
            xtal_last <= 1'b0;
        end
        else if (ce)
        begin
            tsync     <= {tsync[1:0], ltog};
            pin_meta  <= {battery_low_cmp, main_supply_ok, xtal_in};
            pin_sync  <= pin_meta;
            xtal_last <= pin_sync[0];
        end
    end

    assign req_ev     = tsync[2] ^ tsync[1];
    assign main_s     = pin_sync[1];
    assign batt_s     = pin_sync[2];
    assign osc_stop   = ctrl[`RTC_CTL_OSC_STOP];
    assign alm_access = req_ev && lreq.addr >= `RTC_A_ALM_FIRST
                        && lreq.addr <= `RTC_A_ALM_LAST;
    // control stays writable under lock, else the lock could never be released
    assign host_wr    = req_ev && lreq.wr
                        && (!ctrl[`RTC_CTL_LOCK] || lreq.addr == `RTC_A_CTRL);

    // one-second divider on crystal rising edges, stopped while oscillator stop is set
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            div    <= '0;
            tick   <= 1'b0;
            tick_d <= 1'b0;
        end
        else if (ce)
        begin
            tick   <= 1'b0;
            tick_d <= tick;
            if (!osc_stop && pin_sync[0] && !xtal_last)
            begin
                if (div == DW'(XTAL_DIV - 1))
                begin
                    div  <= '0;
                    tick <= 1'b1;
                end
                else
                    div <= div + 1'b1;
            end
        end
    end

    // hour increments taken apart here, a call result cannot be part-selected
    assign hr12_inc = bcd_inc({3'b000, tm[2][4:0]});
    assign hr24_inc = bcd_inc({2'b00, tm[2][5:0]});

    // calendar carry chain, all in bcd
    always_comb
    begin
        leap       = tm[6][4] ? (tm[6][3:0] == 4'h2 || tm[6][3:0] == 4'h6)
                              : (tm[6][3:0] == 4'h0 || tm[6][3:0] == 4'h4 || tm[6][3:0] == 4'h8);
        c_min      = tm[0] == 8'h59;
        next_sec   = c_min ? 8'h00 : bcd_inc(tm[0]);
        c_hour     = c_min && tm[1] == 8'h59;
        next_min   = (tm[1] == 8'h59) ? 8'h00 : bcd_inc(tm[1]);
        if (tm[2][`RTC_HR_MODE])
        begin
            // 12-hour: 11 flips the meridiem, 12 rolls to 01
            c_day = tm[2][`RTC_HR_PM] && tm[2][4:0] == 5'h11;
            if (tm[2][4:0] == 5'h12)
                next_hour = {tm[2][7:5], 5'h01};
            else if (tm[2][4:0] == 5'h11)
                next_hour = {tm[2][7:6], ~tm[2][5], 5'h12};
            else
                next_hour = {tm[2][7:5], hr12_inc[4:0]};
        end
        else
        begin
            // 24-hour: bit 5 is the tens-of-twenty bit
            c_day     = tm[2][5:0] == 6'h23;
            next_hour = c_day ? 8'h00 : {2'b00, hr24_inc[5:0]};
        end
        c_day      = c_day && c_hour;
        next_day   = (tm[3] == 8'h07) ? 8'h01 : tm[3] + 8'h01;
        c_month    = c_day && tm[4] == month_days(tm[5], leap);
        next_date  = (tm[4] == month_days(tm[5], leap)) ? 8'h01 : bcd_inc(tm[4]);
        c_year     = c_month && tm[5] == 8'h12;
        next_month = (tm[5] == 8'h12) ? 8'h01 : bcd_inc(tm[5]);
        next_year  = (tm[6] == 8'h99) ? 8'h00 : bcd_inc(tm[6]);
    end

    // time and alarm bytes; a host write in a tick cycle wins and drops that tick
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            for (int i = 0; i < `RTC_NUM_TM; i++)
                tm[i] <= TM_RESET[8*i +: 8];
        end
        else if (ce)
        begin
            if (host_wr && lreq.addr <= `RTC_A_ALM_LAST)
                tm[lreq.addr[3:0]] <= lreq.data & TM_WMASK[8*lreq.addr[3:0] +: 8];
            else if (tick)
            begin
                tm[0] <= next_sec;
                if (c_min)
                    tm[1] <= next_min;
                if (c_hour)
                    tm[2] <= next_hour;
                if (c_day)
                begin
                    tm[3] <= next_day;
                    tm[4] <= next_date;
                end
                if (c_month)
                    tm[5] <= next_month;
                if (c_year)
                    tm[6] <= next_year;
            end
        end
    end

    // control and watchdog delay; power-up values as the reset constants
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            ctrl <= `RTC_CTRL_RESET;
            wdog <= `RTC_WDOG_RESET;
        end
        else if (ce && host_wr)
        begin
            if (lreq.addr == `RTC_A_CTRL)
                ctrl <= lreq.data & `RTC_CTRL_WMASK;
            if (lreq.addr == `RTC_A_WDOG)
                wdog <= lreq.data & `RTC_WDOG_WMASK;
        end
    end

    // converter result, loaded by the converter's own done strobe
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            adc_reg <= 8'h00;
        else if (ce && conv.done)
            adc_reg <= conv.data;
    end

    // per-field alarm hit: mask bit excludes the field
    generate
        for (genvar g = 0; g < 4; g++)
        begin : g_alarm
            assign fld_hit[g] = tm[`RTC_A_ALM_FIRST + g][`RTC_ALM_MASK]
                                || tm[`RTC_A_ALM_FIRST + g][6:0] == tm[g][6:0];
        end
    endgenerate

    // flag sets once per tick after the count settles; set beats a same-cycle clear
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            alarm_flag <= 1'b0;
        else if (ce)
        begin
            if (tick_d && &fld_hit)
                alarm_flag <= 1'b1;
            else if (alm_access)
                alarm_flag <= 1'b0;
        end
    end

    // read mux
    always_comb
    begin
        if (lreq.addr <= `RTC_A_ALM_LAST)
            rd_val = tm[lreq.addr[3:0]];
        else
        begin
            case (lreq.addr)
                `RTC_A_CTRL: rd_val = ctrl;
                `RTC_A_STAT: rd_val = {conv.pending, batt_s, 5'b0_0000, alarm_flag};
                `RTC_A_WDOG: rd_val = wdog;
                `RTC_A_ADC:  rd_val = adc_reg;
                default:     rd_val = 8'h00;
            endcase
        end
    end

    // read word held stable until the next request from the link side
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            rd_hold <= 8'h00;
        else if (ce && req_ev && !lreq.wr)
            rd_hold <= rd_val;
    end

    // registered outputs
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            irq            <= 1'b0;
            osc_run        <= 1'b0;
            standby        <= 1'b0;
            adc_enable     <= 1'b0;
            adc_input_sel  <= 3'b000;
            watchdog_delay <= 2'b00;
        end
        else if (ce)
        begin
            irq            <= alarm_flag && ctrl[`RTC_CTL_AIE];
            osc_run        <= !osc_stop || main_s;
            standby        <= osc_stop && !main_s;
            adc_enable     <= ctrl[`RTC_CTL_CHAN_HI] || ctrl[`RTC_CTL_CHAN_LO];
            case ({ctrl[`RTC_CTL_CHAN_HI], ctrl[`RTC_CTL_CHAN_LO]})
                2'b01:   adc_input_sel <= 3'b001;
                2'b10:   adc_input_sel <= 3'b010;
                2'b11:   adc_input_sel <= 3'b100;
                default: adc_input_sel <= 3'b000;
            endcase
            watchdog_delay <= wdog[1:0];
        end
    end
endmodule : rtc_core

//--- verif/rtc_core_assertions.sv
// concurrent checks on the rtc core ports
`timescale 1ns/1ps
module rtc_core_assertions
    import rtc_pkg::*;
#(
    parameter int XTAL_DIV = 4
)(
    input logic       sys_clk,
    input logic       rst,
    input logic       link_sclk,
    input logic       link_cs,
    input logic       link_io_out,
    input logic       link_io_oe_n,
    input logic       main_supply_ok,
    input logic       irq,
    input logic       osc_run,
    input logic       standby,
    input logic       adc_enable,
    input logic [2:0] adc_input_sel,
    input logic [1:0] watchdog_delay
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    // six cycles cover the supply synchroniser and the output register
    sequence s_main_steady;
        main_supply_ok [*6];
    endsequence
    // sclk high at two samples means no falling edge between them
    sequence s_shift_quiet;
        (link_cs && link_sclk) ##1 (link_cs && link_sclk);
    endsequence

    a_sel_one_hot: assert property ($onehot0(adc_input_sel))
        else $error("input select not one-hot");
    a_adc_en_sel: assert property (adc_enable == (adc_input_sel != 3'b000))
        else $error("converter enable disagrees with select");
    a_standby_halts: assert property (standby |-> !osc_run)
        else $error("oscillator running in standby");
    a_main_keeps_osc: assert property (s_main_steady |-> osc_run && !standby)
        else $error("oscillator stopped on main supply");
    a_cs_low_idle: assert property (!link_cs |-> link_io_oe_n && !link_io_out)
        else $error("data pin driven without chip select");
    a_oe_needs_cs: assert property ($fell(link_io_oe_n) |-> link_cs)
        else $error("data pin enabled outside a frame");
    a_out_on_fall: assert property (s_shift_quiet |-> $stable(link_io_out) && $stable(link_io_oe_n))
        else $error("read data changed while sclk high");
    a_irq_holds: assert property ($fell(irq) |-> $past(link_cs, 1) || $past(link_cs, 8))
        else $error("interrupt dropped without host access");
    a_rst_defaults: assert property ($fell(rst) |=> watchdog_delay == 2'b11 && !irq && !adc_enable)
        else $error("wrong outputs after reset");
endmodule : rtc_core_assertions

//--- verif/rtc_host_model.sv
// host side of the three-wire serial register port
`timescale 1ns/1ps
module rtc_host_model (
    output logic link_sclk,
    output logic link_cs,
    output logic io_line,
    input  logic dev_out,
    input  logic dev_oe_n
);
    logic host_oe;
    logic host_do;
    logic last_v;

    // no pull on the data pin: a released line shows the inverse of its last level
    assign io_line = !dev_oe_n ? dev_out : (host_oe ? host_do : ~last_v);
    always @(link_sclk)
        if (!dev_oe_n || host_oe)
            last_v <= io_line;

    // sclk stands low outside frames
    initial
    begin
        link_sclk = 1'b0;
        link_cs   = 1'b0;
        host_oe   = 1'b0;
        host_do   = 1'b0;
        last_v    = 1'b0;
        // a definite falling select after time zero clears the link framing
        #1 link_cs = 1'b1;
        #1 link_cs = 1'b0;
    end

    // command byte then n data bytes, lsb first, 64 ns bit time
    task automatic frame(input logic [7:0] cmd, input int n, input logic [31:0] wd,
                         output logic [31:0] rd);
        rd = 32'h0000_0000;
        link_cs = 1'b1;
        for (int i = 0; i < 8 + 8 * n; i++)
        begin
            host_do = (i < 8) ? cmd[i] : wd[i - 8];
            host_oe = (i < 8) || cmd[7];
            if (i >= 8 && !cmd[7])
                rd[i - 8] = io_line;
            #16 link_sclk = 1'b1;
            #32 link_sclk = 1'b0;
            #16;
        end
        link_cs = 1'b0;
        host_oe = 1'b0;
        #200; // room for the write to land in the core
    endtask : frame
endmodule : rtc_host_model

//--- verif/rtc_alarm_control_status_tb_top.sv
// self-checking bench for the rtc core through its serial port
`timescale 1ns/1ps
`include "rtc_consts.svh"
module rtc_alarm_control_status_tb_top
    import rtc_pkg::*;
;
    localparam int XTAL_DIV = 4;
    logic        sys_clk;
    logic        rst;
    logic        link_sclk;
    logic        link_cs;
    logic        io_line;
    logic        link_io_out;
    logic        link_io_oe_n;
    logic        xtal_in;
    logic        main_supply_ok;
    logic        battery_low_cmp;
    rtc_conv_t   conv;
    logic        irq;
    logic        osc_run;
    logic        standby;
    logic        adc_enable;
    logic [2:0]  adc_input_sel;
    logic [1:0]  watchdog_delay;
    logic [31:0] rd;
    logic [32:0] cases [5];
    int          errors;
    int          checks;

    rtc_host_model i_rtc_host_model (
        .link_sclk (link_sclk),
        .link_cs   (link_cs),
        .io_line   (io_line),
        .dev_out   (link_io_out),
        .dev_oe_n  (link_io_oe_n)
    );

    rtc_core #(.XTAL_DIV(XTAL_DIV)) i_rtc_core (
        .sys_clk         (sys_clk),
        .rst             (rst),
        .ce              (1'b1),
        .link_sclk       (link_sclk),
        .link_cs         (link_cs),
        .link_io_in      (io_line),
        .link_io_out     (link_io_out),
        .link_io_oe_n    (link_io_oe_n),
        .xtal_in         (xtal_in),
        .main_supply_ok  (main_supply_ok),
        .battery_low_cmp (battery_low_cmp),
        .conv            (conv),
        .irq             (irq),
        .osc_run         (osc_run),
        .standby         (standby),
        .adc_enable      (adc_enable),
        .adc_input_sel   (adc_input_sel),
        .watchdog_delay  (watchdog_delay)
    );

    // 200 MHz core clock and a 1 us crystal, so a second is 4 us
    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    initial
    begin
        xtal_in = 1'b0;
        forever #500 xtal_in = ~xtal_in;
    end

    task automatic stop_test;
        $display("Checks %0d, errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : cyc

    task automatic wr(input logic [6:0] a, input int n, input logic [31:0] d);
        i_rtc_host_model.frame({1'b1, a}, n, d, rd);
    endtask : wr

    task automatic rdc(input logic [6:0] a, input int n, input logic [31:0] exp);
        i_rtc_host_model.frame({1'b0, a}, n, 32'h0000_0000, rd);
        chk(rd, exp);
    endtask : rdc

    // load time and alarm while stopped, run with irq enabled, stop again
    task automatic alarm_run(input logic [31:0] t, input logic [31:0] a, input logic e);
        int k;
        wr(`RTC_A_CTRL, 1, 32'h0000_0080);
        wr(`RTC_A_SEC, 4, t);
        wr(`RTC_A_ALM_FIRST, 4, a);
        wr(`RTC_A_CTRL, 1, 32'h0000_0001);
        k = 0;
        while (irq !== 1'b1 && k < 2400)
        begin
            cyc(1);
            k++;
        end
        chk(irq, e);
        wr(`RTC_A_CTRL, 1, 32'h0000_0081);
    endtask : alarm_run

    // run away guard, well past the expected run time
    initial
    begin
        #400000;
        errors++;
        $display("Error at %0t ns: watchdog expired", $time);
        stop_test();
    end

    // main sequence
    initial
    begin
        errors = 0;
        checks = 0;
        rst = 1'b0;
        main_supply_ok = 1'b1;
        battery_low_cmp = 1'b0;
        conv = '0;
        cases[0] = {32'h0100_0059, 1'b1};
        cases[1] = {32'h0200_0059, 1'b0};
        cases[2] = {32'h8200_0059, 1'b1};
        cases[3] = {32'h8285_0059, 1'b1};
        cases[4] = {32'h8285_8559, 1'b1};
        // rising reset edge after time zero so the link toggle is cleared too
        #1 rst = 1'b1;
        repeat (20) @(posedge sys_clk);
        #1 rst = 1'b0;
        cyc(5);
        chk(watchdog_delay, 2'b11);
        chk({osc_run, standby}, 2'b10);
        rdc(`RTC_A_CTRL, 1, 32'h0000_0080);
        rdc(`RTC_A_WDOG, 1, 32'h0000_0003);
        rdc(`RTC_A_SEC, 4, 32'h0100_0000);
        // lock set: clock writes must be dropped
        wr(`RTC_A_CTRL, 1, 32'h0000_00C0);
        wr(`RTC_A_SEC, 1, 32'h0000_0033);
        rdc(`RTC_A_SEC, 1, 32'h0000_0000);
        wr(`RTC_A_CTRL, 1, 32'h0000_008E);
        rdc(`RTC_A_CTRL, 1, 32'h0000_0080);
        wr(`RTC_A_MIN, 1, 32'h0000_00D9);
        rdc(`RTC_A_MIN, 1, 32'h0000_0059);
        wr(7'h0F, 1, 32'h0000_0055);
        rdc(7'h0F, 1, 32'h0000_0000);
        rdc(7'h7F, 1, 32'h0000_0000);
        // every converter channel code
        for (int c = 0; c < 4; c++)
        begin
            wr(`RTC_A_CTRL, 1, {24'h00_0000, 2'b10, c[1:0], 4'h0});
            cyc(4);
            chk({adc_enable, adc_input_sel}, (c == 0) ? 4'h0 : {1'b1, 3'b001 << (c - 1)});
        end
        // backup supply with stop set halts the oscillator
        main_supply_ok = 1'b0;
        cyc(10);
        chk({osc_run, standby}, 2'b01);
        main_supply_ok = 1'b1;
        cyc(10);
        chk({osc_run, standby}, 2'b10);
        // converter result, pending and battery status
        conv.pending = 1'b1;
        conv.data = 8'hA5;
        battery_low_cmp = 1'b1;
        cyc(1);
        conv.done = 1'b1;
        cyc(1);
        conv.done = 1'b0;
        cyc(8);
        rdc(`RTC_A_ADC, 1, 32'h0000_00A5);
        rdc(`RTC_A_STAT, 1, 32'h0000_00C0);
        conv.pending = 1'b0;
        battery_low_cmp = 1'b0;
        // mask combinations, day mismatch must stay quiet
        for (int i = 0; i < 5; i++)
            alarm_run(32'h0100_0058, cases[i][32:1], cases[i][0]);
        chk(irq, 1'b1);
        wr(`RTC_A_CTRL, 1, 32'h0000_0080);
        cyc(3);
        chk(irq, 1'b0);
        rdc(`RTC_A_STAT, 1, 32'h0000_0001);
        rdc(`RTC_A_ALM_FIRST, 1, 32'h0000_0059);
        rdc(`RTC_A_STAT, 1, 32'h0000_0000);
        // hour rollover in both modes, one tick each
        alarm_run(32'h0171_5959, 32'h8080_8080, 1'b1);
        rdc(`RTC_A_SEC, 4, 32'h0252_0000);
        alarm_run(32'h0119_5959, 32'h8080_8080, 1'b1);
        rdc(`RTC_A_SEC, 4, 32'h0120_0000);
        stop_test();
    end
endmodule : rtc_alarm_control_status_tb_top

bind rtc_core rtc_core_assertions #(.XTAL_DIV(XTAL_DIV)) i_rtc_core_assertions (
    .sys_clk        (sys_clk),
    .rst            (rst),
    .link_sclk      (link_sclk),
    .link_cs        (link_cs),
    .link_io_out    (link_io_out),
    .link_io_oe_n   (link_io_oe_n),
    .main_supply_ok (main_supply_ok),
    .irq            (irq),
    .osc_run        (osc_run),
    .standby        (standby),
    .adc_enable     (adc_enable),
    .adc_input_sel  (adc_input_sel),
    .watchdog_delay (watchdog_delay)
);
